// ### verilog/ais_input_select.sv
// converter input selection, scan mask and pin configuration registers
`timescale 1ns/1ps
// Contract
// - slot A negative: 1 input one, 0 reference
// - slot B negative bit fifteen, same encoding
// - slot A positive field selects input n
// - slot B positive field bits 12-8
// - second converter positive limited to 0-15
// - unused select bits ignore writes, read zero
// - upper scan bit i includes input 16+i
// - lower scan bit i includes input i
// - all scan bits writable regardless of part
// - missing scanned input converts negative reference
// - config bit 1: digital, read enabled, ground
// - config bit 0: analog, read off, sample
// - missing pin config bits stored, no effect
// - module off forces all pins digital
// - both lower configs affect shared pins
// - second converter has no upper config
// - upper config bit i controls input 16+i
// - slot A scan steps through scan mask
// - alternate mode switches A then B
module ais_input_select #(
  parameter int NINPUTS = 32,
  parameter logic [31:0] PRESENT = 32'hFFFFFFFF,
  parameter bit SECOND = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sample pulse from conversion sequencer
  input wire logic sample_done,
  // converter input multiplexer
  output logic [4:0] ch0_pos_sel_q,
  output logic ch0_neg_sel_q,
  output logic ch0_pos_is_ref_q,
  // pin mode outputs
  output logic [31:0] pin_digital_q,
  output logic [31:0] port_read_en_q,
  output logic [31:0] mux_to_ground_q
);
  // register storage
  logic [15:0] ch0_q;
  logic [15:0] scan_hi_q;
  logic [15:0] scan_lo_q;
  logic [15:0] pin_digital_mode_bits_hi_q;
  logic [15:0] pin_digital_mode_bits_lo_q;
  logic [15:0] pin_digital_mode_bits_lo2_q; // other converter's lower config mirror
  logic [3:0] ctrl_q;
  // sequencing state
  logic slot_b_q; // alternate slot pointer
  logic [4:0] scan_pos_q; // current scanned input
  logic ack_q; // one wait cycle then accept
  // derived
  logic [31:0] scan_mask;
  logic [31:0] pin_digital_mode_bits_all;
  logic [31:0] pin_dig;
  logic [4:0] scan_nxt;
  logic scan_any;
  logic [15:0] wmask;
  logic [31:0] rdata;
  logic req;
  logic wr_go;

  // assemble full-width masks from the half registers
  assign scan_mask = {scan_hi_q, scan_lo_q};
  // second converter has no upper config storage
  assign pin_digital_mode_bits_all = SECOND ? {16'h0000, pin_digital_mode_bits_lo_q} :
                    {pin_digital_mode_bits_hi_q, pin_digital_mode_bits_lo_q};
  assign req = avs_read | avs_write;
  assign wr_go = avs_write & ack_q;
  // byte lanes mapped onto the 16-bit registers
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // next scan position search
  ais_scan_next #(.N(32)) u_scan (
    .mask(scan_mask),
    .cur(scan_pos_q),
    .nxt(scan_nxt),
    .any(scan_any)
  );

  // pin mode decision
  ais_pin_mode #(.N(32), .NSHARED(16)) u_pins (
    .cfg(pin_digital_mode_bits_all),
    .cfg2(pin_digital_mode_bits_lo2_q),
    .present(PRESENT),
    .off(ctrl_q[ais_pkg::POS_OFF]),
    .digital(pin_dig)
  );

  // bus handshake: waitrequest high on the first request cycle, low next
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // waitrequest registered: low only in the accepting cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & ~ack_q);
    end
  end

  // channel 0 select register; reserved bits masked on write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ch0_q <= ais_pkg::RST16;
    end else if (wr_go && avs_address == ais_pkg::OFS_CH0_SEL) begin
      ch0_q <= (ch0_q & ~wmask) |
               (avs_writedata[15:0] & wmask & ais_pkg::CH0_WMASK);
    end
  end

  // scan include registers, every bit writable on every part
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scan_hi_q <= ais_pkg::RST16;
      scan_lo_q <= ais_pkg::RST16;
    end else if (wr_go) begin
      if (avs_address == ais_pkg::OFS_SCAN_HI) begin
        scan_hi_q <= (scan_hi_q & ~wmask) |
                     (avs_writedata[15:0] & wmask);
      end
      if (avs_address == ais_pkg::OFS_SCAN_LO) begin
        scan_lo_q <= (scan_lo_q & ~wmask) |
                     (avs_writedata[15:0] & wmask);
      end
    end
  end

  // pin config registers; bits of missing pins still stored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_digital_mode_bits_hi_q <= ais_pkg::RST16;
      pin_digital_mode_bits_lo_q <= ais_pkg::RST16;
      pin_digital_mode_bits_lo2_q <= ais_pkg::RST16;
    end else if (wr_go) begin
      if (avs_address == ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_HI && !SECOND) begin
        pin_digital_mode_bits_hi_q <= (pin_digital_mode_bits_hi_q & ~wmask) |
                     (avs_writedata[15:0] & wmask);
      end
      if (avs_address == ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO) begin
        pin_digital_mode_bits_lo_q <= (pin_digital_mode_bits_lo_q & ~wmask) |
                     (avs_writedata[15:0] & wmask);
      end
      if (avs_address == ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO2) begin
        pin_digital_mode_bits_lo2_q <= (pin_digital_mode_bits_lo2_q & ~wmask) |
                      (avs_writedata[15:0] & wmask);
      end
    end
  end

  // control bits: alternate, scan enable, module off, manual step
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= 4'h0;
    end else if (wr_go && avs_address == ais_pkg::OFS_CTRL
                 && avs_byteenable[0]) begin
      ctrl_q <= avs_writedata[3:0];
    end else begin
      ctrl_q[ais_pkg::POS_STEP] <= 1'b0; // step is self-clearing
    end
  end

  // read mux; unmapped addresses return zero
  always_comb begin
    rdata = 32'h00000000;
    unique case (avs_address)
      ais_pkg::OFS_CH0_SEL: rdata[15:0] = ch0_q;
      ais_pkg::OFS_SCAN_HI: rdata[15:0] = scan_hi_q;
      ais_pkg::OFS_SCAN_LO: rdata[15:0] = scan_lo_q;
      // second converter reads zero where the upper config would be
      ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_HI: rdata[15:0] = SECOND ? 16'h0000 : pin_digital_mode_bits_hi_q;
      ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO: rdata[15:0] = pin_digital_mode_bits_lo_q;
      ais_pkg::OFS_CTRL: rdata[3:0] = {1'b0, ctrl_q[2:0]};
      ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO2: rdata[15:0] = pin_digital_mode_bits_lo2_q;
      ais_pkg::OFS_STATUS: rdata[5:0] = {slot_b_q, scan_pos_q};
      default: rdata = 32'h00000000;
    endcase
  end

  // read data registered in the wait cycle, held through the accept cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else if (req && !ack_q) begin
      avs_readdata <= rdata;
    end
  end

  // alternate slot pointer toggles per sample only in alternate mode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      slot_b_q <= 1'b0;
    end else if (!ctrl_q[ais_pkg::POS_ALTERNATE_SLOT_SELECT]) begin
      slot_b_q <= 1'b0;
    end else if (sample_done || ctrl_q[ais_pkg::POS_STEP]) begin
      slot_b_q <= ~slot_b_q;
    end
  end

  // scan position advances after each slot A sample, ascending with wrap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scan_pos_q <= ais_pkg::SEL_ZERO;
    end else if (!ctrl_q[ais_pkg::POS_SCAN]) begin
      // restart from the lowest included input when scanning resumes, or from input 31 if it is included
      scan_pos_q <= 5'h1F;
    end else if ((sample_done || ctrl_q[ais_pkg::POS_STEP]) && !slot_b_q
                 && scan_any) begin
      scan_pos_q <= scan_nxt;
    end else if (scan_any && !scan_mask[scan_pos_q]) begin
      // mask changed under us: move onto an included input
      scan_pos_q <= scan_nxt;
    end
  end

  // channel 0 multiplexer selection
  always_ff @(posedge clk) begin
    logic [4:0] pos;
    logic neg;
    if (!resetn) begin
      ch0_pos_sel_q <= ais_pkg::SEL_ZERO;
      ch0_neg_sel_q <= ais_pkg::NEG_REF;
      ch0_pos_is_ref_q <= 1'b0;
    end else begin
      if (slot_b_q) begin
        pos = ch0_q[ais_pkg::POS_SB_LSB +: 5];
        neg = ch0_q[ais_pkg::POS_NB];
      end else if (ctrl_q[ais_pkg::POS_SCAN] && scan_any) begin
        pos = scan_pos_q;
        neg = ch0_q[ais_pkg::POS_NA];
      end else begin
        pos = ch0_q[ais_pkg::POS_SA_LSB +: 5];
        neg = ch0_q[ais_pkg::POS_NA];
      end
      if (SECOND && pos > ais_pkg::SECOND_MAX) begin
        pos = {1'b0, pos[3:0]};
      end
      ch0_pos_sel_q <= pos;
      ch0_neg_sel_q <= neg;
      // a missing input converts the negative reference
      ch0_pos_is_ref_q <= ~PRESENT[pos];
    end
  end

  // pin outputs: digital enables read and grounds mux, analog the reverse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_digital_q <= 32'hFFFFFFFF;
      port_read_en_q <= 32'hFFFFFFFF;
      mux_to_ground_q <= 32'hFFFFFFFF;
    end else begin
      pin_digital_q <= pin_dig;
      port_read_en_q <= pin_dig;
      mux_to_ground_q <= pin_dig;
    end
  end
endmodule : ais_input_select

// ### verilog/ais_pkg.sv
// package: register map, field layout and reset values for input selection
package ais_pkg;
  // register word offsets (byte addresses, one aligned word each)
  localparam logic [4:0] OFS_CH0_SEL = 5'h00;
  localparam logic [4:0] OFS_SCAN_HI = 5'h04;
  localparam logic [4:0] OFS_SCAN_LO = 5'h08;
  localparam logic [4:0] OFS_PIN_DIGITAL_MODE_BITS_HI = 5'h0C;
  localparam logic [4:0] OFS_PIN_DIGITAL_MODE_BITS_LO = 5'h10;
  localparam logic [4:0] OFS_CTRL = 5'h14;
  localparam logic [4:0] OFS_PIN_DIGITAL_MODE_BITS_LO2 = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;
  // channel 0 select field positions
  localparam int POS_SA_LSB = 0;
  localparam int POS_NA = 7;
  localparam int POS_SB_LSB = 8;
  localparam int POS_NB = 15;
  // writable bits of channel 0 select; 14:13 and 6:5 stay zero
  localparam logic [15:0] CH0_WMASK = 16'h9F9F;
  // control register bit positions
  localparam int POS_ALTERNATE_SLOT_SELECT = 0;
  localparam int POS_SCAN = 1;
  localparam int POS_OFF = 2;
  localparam int POS_STEP = 3;
  // reset values
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [4:0] SEL_ZERO = 5'h00;
  // second converter only reaches inputs up to this index
  localparam logic [4:0] SECOND_MAX = 5'h0F;
  // negative input encodings
  localparam logic NEG_REF = 1'b0;
endpackage : ais_pkg

// ### verilog/ais_scan_next.sv
// next scanned input: lowest included index above the current one, wrapping
`timescale 1ns/1ps
module ais_scan_next #(
  parameter int N = 32
) (
  // scan mask and current position
  input wire logic [N-1:0] mask,
  input wire logic [4:0] cur,
  // result
  output logic [4:0] nxt,
  output logic any
);
  // search the upper part first, fall back to the lowest set bit
  always_comb begin
    logic found_hi;
    logic found_lo;
    found_hi = 1'b0;
    found_lo = 1'b0;
    nxt = cur;
    any = |mask;
    for (int i = N - 1; i >= 0; i--) begin
      if (mask[i] && (5'(i) > cur)) begin
        nxt = 5'(i);
        found_hi = 1'b1;
      end
    end
    if (!found_hi) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (mask[i]) begin
          nxt = 5'(i);
          found_lo = 1'b1;
        end
      end
    end
    if (!found_lo && !found_hi) begin
      nxt = cur;
    end
  end
endmodule : ais_scan_next

// ### verilog/ais_pin_mode.sv
// per-pin analog/digital decision from both converters' configuration
`timescale 1ns/1ps
module ais_pin_mode #(
  parameter int N = 32,
  parameter int NSHARED = 16
) (
  // configuration inputs
  input wire logic [N-1:0] cfg,
  input wire logic [NSHARED-1:0] cfg2,
  input wire logic [N-1:0] present,
  input wire logic off,
  // per-pin digital mode
  output logic [N-1:0] digital
);
  // one decision per pin
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      if (g < NSHARED) begin : g_sh
        // either converter forcing digital wins on shared pins
        assign digital[g] = off | ~present[g] | cfg[g] | cfg2[g];
      end else begin : g_hi
        assign digital[g] = off | ~present[g] | cfg[g];
      end
    end
  endgenerate
endmodule : ais_pin_mode

// ### testbench/ais_input_select_asserts.sv
// checker: bus timing and selection/pin output relations
`timescale 1ns/1ps
module ais_input_select_asserts #(
  parameter logic [31:0] PRESENT = 32'hFFFFFFFF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sequencer pulse and outputs
  input wire logic sample_done,
  input wire logic [4:0] ch0_pos_sel_q,
  input wire logic ch0_neg_sel_q,
  input wire logic ch0_pos_is_ref_q,
  input wire logic [31:0] pin_digital_q,
  input wire logic [31:0] port_read_en_q,
  input wire logic [31:0] mux_to_ground_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // one wait cycle, so the answer is seen at the second edge
  a_answer_time: assert property (
    $rose(avs_read || avs_write) |-> ##1 !avs_waitrequest)
    else $error("bus answer not at second edge");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_en_dig: assert property (
    port_read_en_q == pin_digital_q) else $error("read enable mismatch");
  a_ground_dig: assert property (
    mux_to_ground_q == pin_digital_q) else $error("ground mux mismatch");
  a_reserved_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == ais_pkg::OFS_CH0_SEL
    |-> (avs_readdata[15:0] & ~ais_pkg::CH0_WMASK) == 16'h0000)
    else $error("reserved select bits not zero");
  // first edge after release still sees reset-time values, so skip it
  a_ref_tracks: assert property (
    $past(resetn) |-> ch0_pos_is_ref_q == !PRESENT[ch0_pos_sel_q])
    else $error("reference flag wrong");
  a_off_digital: assert property (
    avs_write && !avs_waitrequest && avs_address == ais_pkg::OFS_CTRL
    && avs_byteenable[0] && avs_writedata[ais_pkg::POS_OFF]
    |-> ##[1:2] (pin_digital_q & PRESENT) == PRESENT)
    else $error("module off left a pin analog");
  a_sel_stable: assert property (
    (!avs_write && !sample_done) [*3] |=> $stable(ch0_pos_sel_q))
    else $error("select moved without cause");
endmodule : ais_input_select_asserts

bind ais_input_select ais_input_select_asserts #(.PRESENT(PRESENT))
  ais_input_select_asserts_i (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_done(sample_done),
  .ch0_pos_sel_q(ch0_pos_sel_q), .ch0_neg_sel_q(ch0_neg_sel_q),
  .ch0_pos_is_ref_q(ch0_pos_is_ref_q), .pin_digital_q(pin_digital_q),
  .port_read_en_q(port_read_en_q), .mux_to_ground_q(mux_to_ground_q));

// ### testbench/ais_input_select_bench.sv
// bench: register access, slot alternation, scan order and pin modes
`timescale 1ns/1ps
module ais_input_select_bench;
  // inputs 28 to 31 absent, to reach the missing-input paths
  localparam logic [31:0] PRES = 32'h0FFFFFFF;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic sample_done = 1'b0;
  logic [31:0] rdata, rd;
  logic wait_s, neg, is_ref;
  logic [4:0] sel;
  logic [31:0] dig, ren, gnd;
  // second-converter instance on the same bus
  logic [31:0] rdata2, rd2;
  logic wait2;
  logic [4:0] sel2;
  int n_fail = 0;
  int checks = 0;
  ais_input_select #(.PRESENT(PRES)) ais_input_select_i (.clk(clk),
    .resetn(resetn), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_s),
    .sample_done(sample_done), .ch0_pos_sel_q(sel),
    .ch0_neg_sel_q(neg), .ch0_pos_is_ref_q(is_ref),
    .pin_digital_q(dig), .port_read_en_q(ren), .mux_to_ground_q(gnd));
  ais_input_select #(.PRESENT(PRES), .SECOND(1'b1)) ais_input_select_i2 (
    .clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata2), .avs_waitrequest(wait2),
    .sample_done(sample_done), .ch0_pos_sel_q(sel2),
    .ch0_neg_sel_q(), .ch0_pos_is_ref_q(),
    .pin_digital_q(), .port_read_en_q(), .mux_to_ground_q());
  // free-running 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // one avalon transfer; request held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr_s <= w;
    rd_s <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wait_s !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      $display("wrong value at %0t: bus timeout", $time);
      end_sim();
    end
    rd = rdata;
    rd2 = rdata2;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : bus
  // let register changes reach the outputs, sample mid-cycle
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task pulse;
    @(posedge clk);
    sample_done <= 1'b1;
    @(posedge clk);
    sample_done <= 1'b0;
    settle();
  endtask : pulse
  task t_reset;
    logic [4:0] ofs[5];
    ofs = '{ais_pkg::OFS_CH0_SEL, ais_pkg::OFS_SCAN_HI,
      ais_pkg::OFS_SCAN_LO, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_HI, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO};
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk(rd, {16'h0000, ais_pkg::RST16});
    end
  endtask : t_reset
  // reserved select bits drop, every upper scan bit sticks
  task t_masks;
    bus(1'b1, ais_pkg::OFS_CH0_SEL, 32'h0000FFFF);
    bus(1'b0, ais_pkg::OFS_CH0_SEL, 32'h0);
    chk(rd, 32'h00009F9F);
    bus(1'b1, ais_pkg::OFS_SCAN_HI, 32'h0000FFFF);
    bus(1'b0, ais_pkg::OFS_SCAN_HI, 32'h0);
    chk(rd, 32'h0000FFFF);
  endtask : t_masks
  task t_alt;
    bus(1'b1, ais_pkg::OFS_CTRL, 32'h00000001);
    bus(1'b1, ais_pkg::OFS_CH0_SEL, 32'h00000983);
    settle();
    chk({sel, neg}, {5'h03, 1'b1});
    pulse();
    chk({sel, neg}, {5'h09, 1'b0});
    pulse();
    chk({sel, neg}, {5'h03, 1'b1});
  endtask : t_alt
  // enabling parks on the lowest included input (1), then each sample
  // steps on to 4, 16, the missing 29, and wraps back to 1
  task t_scan;
    logic [4:0] seq[5];
    seq = '{5'h01, 5'h04, 5'h10, 5'h1D, 5'h01};
    bus(1'b1, ais_pkg::OFS_SCAN_LO, 32'h00000012);
    bus(1'b1, ais_pkg::OFS_SCAN_HI, 32'h00002001);
    bus(1'b1, ais_pkg::OFS_CTRL, 32'h00000002);
    foreach (seq[i]) begin
      if (i > 0) begin
        pulse();
      end else begin
        settle();
      end
      chk(sel, seq[i]);
      chk(is_ref, !PRES[seq[i]]);
      chk(sel2, {1'b0, seq[i][3:0]});
    end
  endtask : t_scan
  task t_pins;
    bus(1'b1, ais_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO, 32'h000000F0);
    bus(1'b1, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_HI, 32'h00008001);
    bus(1'b1, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_LO2, 32'h00000100);
    settle();
    chk(dig & PRES, 32'h000101F0);
    chk(ren & PRES, 32'h000101F0);
    chk(gnd & PRES, 32'h000101F0);
    bus(1'b0, ais_pkg::OFS_PIN_DIGITAL_MODE_BITS_HI, 32'h0);
    chk(rd, 32'h00008001);
    chk(rd2, 32'h00000000);
    bus(1'b1, ais_pkg::OFS_CTRL, 32'h00000004);
    settle();
    chk(dig & PRES, PRES);
  endtask : t_pins
  // main sequence: reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_masks();
    t_alt();
    t_scan();
    t_pins();
    end_sim();
  end
endmodule : ais_input_select_bench
